// ==== swrt_pkg.sv ====
// Purpose: Shared constants and types for the single-wire return-to-one link
// Assumes: clk_sys at 20 MHz, synchronous active-low reset
// Notes:   All slot times are held in ns; cycle counts derive from them

package swrt_pkg;

	// ------------------------------------------------------------
	// Clock and counter width
	// ------------------------------------------------------------
	localparam int CLK_NS = 50;                        // 20 MHz period
	localparam int CNT_W  = 13;                        // Holds every count below

	// ------------------------------------------------------------
	// Link times in ns
	// ------------------------------------------------------------
	localparam int BREAK_TIME_NS           = 200000;  // Host break low time
	localparam int BREAK_DETECT_NS         = 150000;  // Low longer than this is a break
	localparam int BREAK_RECOVERY_TIME_NS  = 40000;   // High after break
	localparam int HOST_BIT_SLOT_PERIOD_NS = 200000;  // Host bit slot
	localparam int HOST_ZERO_LOW_TIME_NS   = 100000;  // Host zero low
	localparam int HOST_ONE_LOW_TIME_NS    = 30000;   // Host one low
	localparam int DEVICE_BIT_SLOT_PERIOD_NS = 200000; // Device bit slot
	localparam int DEVICE_ZERO_LOW_TIME_NS = 100000;  // Device zero low
	localparam int DEVICE_ONE_LOW_TIME_NS  = 30000;   // Device one low
	localparam int DECODE_THRESH_NS        = 65000;   // Between the one and zero lows
	localparam int TURNAROUND_NS           = 200000;  // Device wait before answering
	localparam int RX_TIMEOUT_NS           = 200000;  // Host wait for a device bit

	// ------------------------------------------------------------
	// Cycle counts (least times round up, longest round down)
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0] BRK_CYC    = CNT_W'((BREAK_TIME_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] BRK_DET_CYC = CNT_W'(BREAK_DETECT_NS / CLK_NS);
	localparam logic [CNT_W-1:0] BR_CYC     =
		CNT_W'((BREAK_RECOVERY_TIME_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] HSLOT_CYC  =
		CNT_W'((HOST_BIT_SLOT_PERIOD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] HZERO_CYC  = CNT_W'((HOST_ZERO_LOW_TIME_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] HONE_CYC   = CNT_W'((HOST_ONE_LOW_TIME_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] DSLOT_CYC  =
		CNT_W'((DEVICE_BIT_SLOT_PERIOD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] DZERO_CYC  =
		CNT_W'((DEVICE_ZERO_LOW_TIME_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] DONE_CYC   = CNT_W'((DEVICE_ONE_LOW_TIME_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] THRESH_CYC = CNT_W'(DECODE_THRESH_NS / CLK_NS);
	localparam logic [CNT_W-1:0] TURN_CYC   = CNT_W'((TURNAROUND_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] RXTO_CYC   = CNT_W'(RX_TIMEOUT_NS / CLK_NS);

	// ------------------------------------------------------------
	// Command byte layout
	// ------------------------------------------------------------
	localparam int   CMD_RW_BIT = 7;                   // Direction flag position
	localparam logic RW_READ    = 1'b1;                // Flag value for a read
	localparam logic [2:0] LAST_BIT = 3'h7;            // Index of eighth bit

	// ------------------------------------------------------------
	// State encodings
	// ------------------------------------------------------------
	typedef enum logic [2:0] {D_IDLE, D_BRK, D_REC, D_BIT, D_GAP, D_TURN, D_TXLO, D_TXHI}
		swrt_dev_state_t;
	typedef enum logic [2:0] {H_IDLE, H_BRK, H_REC, H_TXLO, H_TXHI, H_RXW, H_RXLO}
		swrt_hst_state_t;

endpackage

// ==== swrt_if.sv ====
// Purpose: Wired-AND model of the alert and dedicated single-wire lines
// Assumes: Open-drain drivers and an external pull-up on each line
// Notes:   A line is low when any party enables its driver with a low

`timescale 1ns/1ps

interface swrt_if;
	logic dev_alert_o;      // Device alert pin data
	logic dev_alert_oe_n;   // Device alert pin enable, low drives
	logic dev_ded_o;        // Device dedicated pin data
	logic dev_ded_oe_n;     // Device dedicated pin enable, low drives
	logic hst_alert_o;      // Host alert pin data
	logic hst_alert_oe_n;   // Host alert pin enable, low drives
	logic hst_ded_o;        // Host dedicated pin data
	logic hst_ded_oe_n;     // Host dedicated pin enable, low drives
	logic alert_line;       // Resolved alert line level
	logic ded_line;         // Resolved dedicated line level

	// Pull-up wins unless some enabled driver pulls low
	assign alert_line = (dev_alert_oe_n | dev_alert_o) & (hst_alert_oe_n | hst_alert_o);
	assign ded_line   = (dev_ded_oe_n | dev_ded_o) & (hst_ded_oe_n | hst_ded_o);

	modport dev (output dev_alert_o, dev_alert_oe_n, dev_ded_o, dev_ded_oe_n,
		input alert_line, ded_line);
	modport hst (output hst_alert_o, hst_alert_oe_n, hst_ded_o, hst_ded_oe_n,
		input alert_line, ded_line);
endinterface

// ==== swrt_host.sv ====
// Purpose: Host end of the single-wire link, one byte per transaction
// Assumes: Device keeps the device slot times; line inputs synchronous
// Notes:   A missing device bit ends the read with an error flag

`timescale 1ns/1ps

module swrt_host
(
	input  wire logic       clk_sys,     // System clock
	input  wire logic       nrst,        // Synchronous reset, active low
	swrt_if.hst             lnk,         // Link pins
	input  wire logic       use_alert,   // Host attaches to the alert line
	input  wire logic       start,       // Begin a transaction, pulse
	input  wire logic [6:0] cmd_code,    // Command code
	input  wire logic       rd,          // High for a read
	input  wire logic [7:0] wr_data,     // Byte to write
	output logic            busy,        // Transaction in progress
	output logic            done,        // Transaction finished, pulse
	output logic            err,         // Read timed out, with done
	output logic [7:0]      rd_data      // Byte read
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		swrt_pkg::swrt_hst_state_t st;   // Sequencer state
		logic [swrt_pkg::CNT_W-1:0] cnt; // Slot timer
		logic [2:0] bitn;                // Bit index
		logic [7:0] sh;                  // Shift register
		logic [7:0] wd;                  // Pending write byte
		logic       rd;                  // Read transaction
		logic       data_ph;             // Sending the data byte
		logic       alert;               // Line in use
		logic       prev;                // Line one cycle ago
		logic       drive;               // Pulling the line low
		logic       busy;                // Busy flag
		logic       done;                // Done pulse
		logic       err;                 // Error flag
		logic [7:0] rdata;               // Read result
	} swrt_hst_t;

	swrt_hst_t s_ff;     // Registered state
	swrt_hst_t nxt_s;    // Next state
	logic      line;     // Selected line level
	logic      fall;     // Falling edge seen
	logic      rise;     // Rising edge seen
	logic [swrt_pkg::CNT_W-1:0] low_len; // Low time of current bit

	assign line    = s_ff.alert ? lnk.alert_line : lnk.ded_line;
	assign fall    = s_ff.prev & ~line;
	assign rise    = ~s_ff.prev & line;
	assign low_len = s_ff.sh[0] ? swrt_pkg::HONE_CYC : swrt_pkg::HZERO_CYC;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_s      = s_ff;
		nxt_s.prev = line;
		nxt_s.done = 1'b0;
		nxt_s.cnt  = s_ff.cnt + 1'b1;
		case (s_ff.st)
			swrt_pkg::H_IDLE:
			begin
				nxt_s.cnt = '0;
				if (start)
				begin
					// Direction flag on top, code below, sent LSB first
					nxt_s.sh      = {rd, cmd_code};
					nxt_s.wd      = wr_data;
					nxt_s.rd      = rd;
					nxt_s.alert   = use_alert;
					nxt_s.busy    = 1'b1;
					nxt_s.err     = 1'b0;
					nxt_s.drive   = 1'b1;
					nxt_s.st      = swrt_pkg::H_BRK;
				end
			end
			swrt_pkg::H_BRK:
				if (s_ff.cnt == swrt_pkg::BRK_CYC - 1'b1)
				begin
					nxt_s.drive = 1'b0;
					nxt_s.cnt   = '0;
					nxt_s.st    = swrt_pkg::H_REC;
				end
			swrt_pkg::H_REC:
				if (s_ff.cnt == swrt_pkg::BR_CYC - 1'b1)
				begin
					nxt_s.drive   = 1'b1;
					nxt_s.cnt     = '0;
					nxt_s.bitn    = '0;
					nxt_s.data_ph = 1'b0;
					nxt_s.st      = swrt_pkg::H_TXLO;
				end
			swrt_pkg::H_TXLO:
				if (s_ff.cnt == low_len - 1'b1)
				begin
					nxt_s.drive = 1'b0;
					nxt_s.st    = swrt_pkg::H_TXHI;
				end
			swrt_pkg::H_TXHI:
				if (s_ff.cnt == swrt_pkg::HSLOT_CYC - 1'b1)
				begin
					nxt_s.sh   = {1'b0, s_ff.sh[7:1]};
					nxt_s.bitn = s_ff.bitn + 1'b1;
					nxt_s.cnt  = '0;
					nxt_s.st   = swrt_pkg::H_TXLO;
					nxt_s.drive = 1'b1;
					if (s_ff.bitn == swrt_pkg::LAST_BIT)
					begin
						if (s_ff.data_ph)
						begin
							// One byte per transaction
							nxt_s.drive = 1'b0;
							nxt_s.busy  = 1'b0;
							nxt_s.done  = 1'b1;
							nxt_s.st    = swrt_pkg::H_IDLE;
						end
						else if (s_ff.rd)
						begin
							nxt_s.drive = 1'b0;
							nxt_s.st    = swrt_pkg::H_RXW;
						end
						else
						begin
							nxt_s.sh      = s_ff.wd;
							nxt_s.data_ph = 1'b1;
						end
					end
				end
			swrt_pkg::H_RXW:
				if (fall)
				begin
					nxt_s.cnt = '0;
					nxt_s.st  = swrt_pkg::H_RXLO;
				end
				else if (s_ff.cnt == swrt_pkg::RXTO_CYC - 1'b1)
				begin
					// Device silent: give up rather than hang
					nxt_s.err  = 1'b1;
					nxt_s.busy = 1'b0;
					nxt_s.done = 1'b1;
					nxt_s.st   = swrt_pkg::H_IDLE;
				end
			swrt_pkg::H_RXLO:
				if (rise)
				begin
					nxt_s.sh   = {(s_ff.cnt < swrt_pkg::THRESH_CYC), s_ff.sh[7:1]};
					nxt_s.bitn = s_ff.bitn + 1'b1;
					nxt_s.cnt  = '0;
					nxt_s.st   = swrt_pkg::H_RXW;
					if (s_ff.bitn == swrt_pkg::LAST_BIT)
					begin
						nxt_s.rdata = {(s_ff.cnt < swrt_pkg::THRESH_CYC), s_ff.sh[7:1]};
						nxt_s.busy  = 1'b0;
						nxt_s.done  = 1'b1;
						nxt_s.st    = swrt_pkg::H_IDLE;
					end
				end
				else if (s_ff.cnt == swrt_pkg::RXTO_CYC - 1'b1)
				begin
					// Line stuck low
					nxt_s.err  = 1'b1;
					nxt_s.busy = 1'b0;
					nxt_s.done = 1'b1;
					nxt_s.st   = swrt_pkg::H_IDLE;
				end
			default:
				nxt_s.st = swrt_pkg::H_IDLE;
		endcase
	end

	// Register the whole state
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	// ------------------------------------------------------------
	// Pins and outputs
	// ------------------------------------------------------------
	assign lnk.hst_alert_o    = 1'b0;
	assign lnk.hst_ded_o      = 1'b0;
	assign lnk.hst_alert_oe_n = ~(s_ff.drive & s_ff.alert);
	assign lnk.hst_ded_oe_n   = ~(s_ff.drive & ~s_ff.alert);
	assign busy    = s_ff.busy;
	assign done    = s_ff.done;
	assign err     = s_ff.err;
	assign rd_data = s_ff.rdata;

endmodule

// ==== swrt_dev.sv ====
// Purpose: Device end of the single-wire return-to-one link
// Assumes: Host keeps the host slot times; line inputs synchronous
// Notes:   Bits are decoded from low-pulse width; read data is sampled
//          at the end of the turnaround after cmd_valid

`timescale 1ns/1ps

module swrt_dev
(
	input  wire logic       clk_sys,       // System clock
	input  wire logic       nrst,          // Synchronous reset, active low
	swrt_if.dev             lnk,           // Link pins
	input  wire logic       comm_type_cfg, // Setting: single-wire selected
	input  wire logic       alert_pin_cfg, // Setting: use the alert pin
	input  wire logic       swap_mode_cmd, // Swap to configured mode, pulse
	input  wire logic       swap_to_single_wire_cmd, // Swap to link on alert, pulse
	input  wire logic [7:0] rd_data,       // Answer byte for a read
	output logic            sw_mode,       // Link mode active
	output logic            alert_sel,     // Alert pin carries the link
	output logic            cmd_valid,     // Command received, pulse
	output logic [6:0]      cmd_code,      // Received command code
	output logic            cmd_read,      // Received direction is read
	output logic            wr_valid,      // Write byte received, pulse
	output logic [7:0]      wr_data        // Received write byte
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		swrt_pkg::swrt_dev_state_t st;   // Frame state
		logic [swrt_pkg::CNT_W-1:0] cnt; // Pulse and slot timer
		logic [2:0] bitn;                // Bit index
		logic [7:0] sh;                  // Shift register
		logic       data_ph;             // Receiving the data byte
		logic       prev;                // Line one cycle ago
		logic       drive;               // Pulling the line low
		logic       sw_mode;             // Link mode active
		logic       alert;               // Alert pin selected
		logic       init;                // Settings loaded since reset
		logic       cmd_stb;             // Command pulse
		logic       cmd_rd;              // Command direction
		logic [6:0] code;                // Command code
		logic       wr_stb;              // Write pulse
		logic [7:0] wdata;               // Write byte
	} swrt_dev_t;

	swrt_dev_t s_ff;      // Registered state
	swrt_dev_t nxt_s;     // Next state
	logic      line;      // Selected line level
	logic      fall;      // Falling edge seen
	logic      rise;      // Rising edge seen
	logic      bit_val;   // Decoded bit at rising edge
	logic [7:0] rx_byte;  // Byte after this bit shifts in
	logic [swrt_pkg::CNT_W-1:0] low_len; // Low time of bit being sent

	// Only the selected pin is watched; the other one is left alone
	assign line    = s_ff.alert ? lnk.alert_line : lnk.ded_line;
	assign fall    = s_ff.prev & ~line;
	assign rise    = ~s_ff.prev & line;
	assign bit_val = (s_ff.cnt < swrt_pkg::THRESH_CYC);
	assign rx_byte = {bit_val, s_ff.sh[7:1]};
	assign low_len = s_ff.sh[0] ? swrt_pkg::DONE_CYC : swrt_pkg::DZERO_CYC;

	// ------------------------------------------------------------
	// Mode control and frame sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_s         = s_ff;
		nxt_s.prev    = line;
		nxt_s.cmd_stb = 1'b0;
		nxt_s.wr_stb  = 1'b0;
		nxt_s.cnt     = s_ff.cnt + 1'b1;

		// Mode: settings after reset, subcommands at any time
		if (!s_ff.init)
		begin
			nxt_s.init    = 1'b1;
			nxt_s.sw_mode = comm_type_cfg;
			nxt_s.alert   = alert_pin_cfg;
		end
		else if (swap_to_single_wire_cmd)
		begin
			nxt_s.sw_mode = 1'b1;
			nxt_s.alert   = 1'b1;
		end
		else if (swap_mode_cmd)
		begin
			nxt_s.sw_mode = comm_type_cfg;
			nxt_s.alert   = alert_pin_cfg;
		end

		case (s_ff.st)
			swrt_pkg::D_IDLE:
			begin
				// Slave only: nothing happens until the host pulls low
				nxt_s.cnt   = '0;
				nxt_s.drive = 1'b0;
				if (fall)
					nxt_s.st = swrt_pkg::D_BRK;
			end
			swrt_pkg::D_BRK:
			begin
				// Saturate so a held-low line cannot wrap the timer
				if (s_ff.cnt >= swrt_pkg::BRK_DET_CYC)
					nxt_s.cnt = s_ff.cnt;
				if (rise)
				begin
					nxt_s.cnt = '0;
					if (s_ff.cnt >= swrt_pkg::BRK_DET_CYC)
					begin
						nxt_s.bitn    = '0;
						nxt_s.data_ph = 1'b0;
						nxt_s.st      = swrt_pkg::D_REC;
					end
					else
						nxt_s.st = swrt_pkg::D_IDLE;
				end
			end
			swrt_pkg::D_REC,
			swrt_pkg::D_GAP:
				if (fall)
				begin
					nxt_s.cnt = '0;
					nxt_s.st  = swrt_pkg::D_BIT;
				end
			swrt_pkg::D_BIT:
				if (s_ff.cnt >= swrt_pkg::BRK_DET_CYC)
					nxt_s.st = swrt_pkg::D_BRK;
				else if (rise)
				begin
					nxt_s.sh   = rx_byte;
					nxt_s.bitn = s_ff.bitn + 1'b1;
					nxt_s.cnt  = '0;
					nxt_s.st   = swrt_pkg::D_GAP;
					if (s_ff.bitn == swrt_pkg::LAST_BIT)
					begin
						if (s_ff.data_ph)
						begin
							// Frame ends after one byte
							nxt_s.wdata  = rx_byte;
							nxt_s.wr_stb = 1'b1;
							nxt_s.st     = swrt_pkg::D_IDLE;
						end
						else
						begin
							nxt_s.code    = rx_byte[6:0];
							nxt_s.cmd_rd  = (rx_byte[swrt_pkg::CMD_RW_BIT] == swrt_pkg::RW_READ);
							nxt_s.cmd_stb = 1'b1;
							nxt_s.data_ph = 1'b1;
							if (rx_byte[swrt_pkg::CMD_RW_BIT] == swrt_pkg::RW_READ)
								nxt_s.st = swrt_pkg::D_TURN;
						end
					end
				end
			swrt_pkg::D_TURN:
				if (fall)
				begin
					// Host broke in instead of waiting: restart frame
					nxt_s.cnt = '0;
					nxt_s.st  = swrt_pkg::D_BRK;
				end
				else if (s_ff.cnt == swrt_pkg::TURN_CYC - 1'b1)
				begin
					// Late sample gives the user the turnaround to answer
					nxt_s.sh    = rd_data;
					nxt_s.bitn  = '0;
					nxt_s.cnt   = '0;
					nxt_s.drive = 1'b1;
					nxt_s.st    = swrt_pkg::D_TXLO;
				end
			swrt_pkg::D_TXLO:
				if (s_ff.cnt == low_len - 1'b1)
				begin
					nxt_s.drive = 1'b0;
					nxt_s.st    = swrt_pkg::D_TXHI;
				end
			swrt_pkg::D_TXHI:
				if (s_ff.cnt == swrt_pkg::DSLOT_CYC - 1'b1)
				begin
					nxt_s.sh   = {1'b0, s_ff.sh[7:1]};
					nxt_s.bitn = s_ff.bitn + 1'b1;
					nxt_s.cnt  = '0;
					if (s_ff.bitn == swrt_pkg::LAST_BIT)
						nxt_s.st = swrt_pkg::D_IDLE;
					else
					begin
						nxt_s.drive = 1'b1;
						nxt_s.st    = swrt_pkg::D_TXLO;
					end
				end
			default:
				nxt_s.st = swrt_pkg::D_IDLE;
		endcase

		// Out of link mode or mid-swap: release and drop the frame
		if (!nxt_s.sw_mode || (nxt_s.alert != s_ff.alert))
		begin
			nxt_s.st    = swrt_pkg::D_IDLE;
			nxt_s.drive = 1'b0;
		end
	end

	// Register the whole state
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	// ------------------------------------------------------------
	// Pins and outputs
	// ------------------------------------------------------------
	// Data pins stay low; only the enables move, so no high is ever driven
	assign lnk.dev_alert_o    = 1'b0;
	assign lnk.dev_ded_o      = 1'b0;
	assign lnk.dev_alert_oe_n = ~(s_ff.drive & s_ff.alert);
	assign lnk.dev_ded_oe_n   = ~(s_ff.drive & ~s_ff.alert);
	assign sw_mode   = s_ff.sw_mode;
	assign alert_sel = s_ff.alert;
	assign cmd_valid = s_ff.cmd_stb;
	assign cmd_code  = s_ff.code;
	assign cmd_read  = s_ff.cmd_rd;
	assign wr_valid  = s_ff.wr_stb;
	assign wr_data   = s_ff.wdata;

endmodule

// ==== swrt_props.sv ====
// Purpose: Wire checks on the joined single-wire link
// Assumes: One clock; nrst synchronous, active low
// Notes:   Pulse and release runs are counted in helper registers

`timescale 1ns/1ps

module swrt_props
(
	input wire logic clk_sys,        // System clock
	input wire logic nrst,           // Reset, active low
	input wire logic dev_alert_o,    // Device alert data
	input wire logic dev_alert_oe_n, // Device alert enable
	input wire logic dev_ded_o,      // Device dedicated data
	input wire logic dev_ded_oe_n,   // Device dedicated enable
	input wire logic hst_alert_o,    // Host alert data
	input wire logic hst_alert_oe_n, // Host alert enable
	input wire logic hst_ded_o,      // Host dedicated data
	input wire logic hst_ded_oe_n    // Host dedicated enable
);
	// ------------------------------------------------------------
	// Run counters
	// ------------------------------------------------------------
	logic        dev_drv; // Device pulls a line low
	logic        hst_drv; // Host pulls a line low
	logic [12:0] dlo_ff;  // Device low run
	logic [12:0] dhi_ff;  // Device release run
	logic [12:0] hlo_ff;  // Host low run
	logic [12:0] hhi_ff;  // Host release run

	assign dev_drv = !dev_alert_oe_n || !dev_ded_oe_n;
	assign hst_drv = !hst_alert_oe_n || !hst_ded_oe_n;

	// Release runs start saturated so the first pulse after reset passes
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			dlo_ff <= 13'h0000;
			hlo_ff <= 13'h0000;
			dhi_ff <= 13'h1FFF;
			hhi_ff <= 13'h1FFF;
		end
		else
		begin
			dlo_ff <= dev_drv ? dlo_ff + 13'h0001 : 13'h0000;
			hlo_ff <= hst_drv ? hlo_ff + 13'h0001 : 13'h0000;
			dhi_ff <= dev_drv ? 13'h0000 : dhi_ff + 13'(~&dhi_ff);
			hhi_ff <= hst_drv ? 13'h0000 : hhi_ff + 13'(~&hhi_ff);
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	AST_DEV_OD: assert property (!dev_alert_o && !dev_ded_o)
		else $error("device pin data not low");
	AST_HST_OD: assert property (!hst_alert_o && !hst_ded_o)
		else $error("host pin data not low");
	AST_DEV_ONE_PIN: assert property (dev_alert_oe_n || dev_ded_oe_n)
		else $error("device drives both pins");
	AST_NO_CLASH: assert property (!(dev_drv && hst_drv))
		else $error("device drives while host drives");
	AST_DEV_LOW: assert property ($fell(dev_drv) |->
		(dlo_ff == swrt_pkg::DONE_CYC || dlo_ff == swrt_pkg::DZERO_CYC))
		else $error("device low width wrong");
	AST_HST_LOW: assert property ($fell(hst_drv) |->
		(hlo_ff == swrt_pkg::HONE_CYC || hlo_ff == swrt_pkg::HZERO_CYC
		|| hlo_ff == swrt_pkg::BRK_CYC))
		else $error("host low width wrong");
	AST_HST_REL: assert property ($rose(hst_drv) |-> hhi_ff >= swrt_pkg::BR_CYC)
		else $error("host release too short");
	AST_DEV_REL: assert property ($rose(dev_drv) |->
		(hhi_ff >= swrt_pkg::DZERO_CYC && dhi_ff >= swrt_pkg::DZERO_CYC))
		else $error("device starts too soon");
	AST_DEV_HOLD: assert property ($rose(dev_drv) |=> dev_drv [*8])
		else $error("device low pulse cut short");

	// Main scenarios reached
	cover property ($fell(dev_drv) && dlo_ff == swrt_pkg::DZERO_CYC);
	cover property ($fell(dev_drv) && dlo_ff == swrt_pkg::DONE_CYC);
	cover property ($fell(hst_drv) && hlo_ff == swrt_pkg::BRK_CYC);
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for both ends of the link
// Assumes: 50 ns clock; each frame takes some 70k cycles
// Notes:   Expected results queue up as stimulus is driven

`timescale 1ns/1ps

module tb_top;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clk_sys = 0; // System clock
	logic        nrst = 0;    // Reset, active low
	logic        use_alert = 1, start = 0, h_rd = 0, h_busy, h_done, h_err;
	logic [6:0]  h_cmd = 0, d_code;
	logic [7:0]  h_wdat = 0, h_rdat, d_rdat = 0, d_wdat;
	logic        comm_cfg = 1, pin_cfg = 0, swap_m = 0, swap_s = 0;
	logic        sw_mode, alert_sel, cmd_valid, d_read, wr_valid;
	logic [15:0] q_cmd[$], q_wr[$], q_host[$], q_wire[$], e_host, wb = 0;
	int          n_fail = 0, check_count = 0, cyc = 0, lo_n = 0, nbit = 0, seed;

	always #25 clk_sys = ~clk_sys;

	swrt_if swrt_if_inst ();
	swrt_host swrt_host_inst (.clk_sys(clk_sys), .nrst(nrst), .lnk(swrt_if_inst),
		.use_alert(use_alert), .start(start), .cmd_code(h_cmd), .rd(h_rd),
		.wr_data(h_wdat), .busy(h_busy), .done(h_done), .err(h_err), .rd_data(h_rdat));
	swrt_dev swrt_dev_inst (.clk_sys(clk_sys), .nrst(nrst), .lnk(swrt_if_inst),
		.comm_type_cfg(comm_cfg), .alert_pin_cfg(pin_cfg), .swap_mode_cmd(swap_m),
		.swap_to_single_wire_cmd(swap_s), .rd_data(d_rdat), .sw_mode(sw_mode),
		.alert_sel(alert_sel), .cmd_valid(cmd_valid), .cmd_code(d_code),
		.cmd_read(d_read), .wr_valid(wr_valid), .wr_data(d_wdat));
	swrt_props swrt_props_inst (.clk_sys(clk_sys), .nrst(nrst),
		.dev_alert_o(swrt_if_inst.dev_alert_o), .dev_alert_oe_n(swrt_if_inst.dev_alert_oe_n),
		.dev_ded_o(swrt_if_inst.dev_ded_o), .dev_ded_oe_n(swrt_if_inst.dev_ded_oe_n),
		.hst_alert_o(swrt_if_inst.hst_alert_o), .hst_alert_oe_n(swrt_if_inst.hst_alert_oe_n),
		.hst_ded_o(swrt_if_inst.hst_ded_o), .hst_ded_oe_n(swrt_if_inst.hst_ded_oe_n));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// An empty queue yields unknown, so a surplus result fails
	function automatic logic [15:0] pop(ref logic [15:0] q[$]);
		if (q.size() == 0)
			return 'x;
		return q.pop_front();
	endfunction

	task automatic test_done;
		$display("Failures %0d, checks %0d", n_fail, check_count);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Pulse the mode subcommands, then compare both mode outputs
	task automatic mode(logic m, logic s, logic sw, logic sel);
		swap_m <= m;
		swap_s <= s;
		@(posedge clk_sys);
		swap_m <= 0;
		swap_s <= 0;
		repeat (3) @(posedge clk_sys);
		check("sw_mode", sw_mode, sw);
		check("alert_sel", alert_sel, sel);
	endtask

	// One whole frame; the answer byte is set long before turnaround ends
	task automatic xact(logic r, logic [6:0] c, logic [7:0] d);
		q_cmd.push_back({8'h00, r, c});
		q_wire.push_back({d, r, c});
		if (!r)
			q_wr.push_back({8'h00, d});
		q_host.push_back({6'h00, r, 1'b0, d});
		d_rdat <= r ? d : ~d;
		h_rd <= r;
		h_cmd <= c;
		h_wdat <= d;
		start <= 1;
		@(posedge clk_sys);
		start <= 0;
		// Busy rises on the edge that takes start, seen one edge later
		@(posedge clk_sys);
		check("busy", {15'h0000, h_busy}, 16'h0001);
		@(posedge clk_sys iff h_done === 1'b1);
		@(posedge clk_sys);
	endtask

	// ------------------------------------------------------------
	// Result and wire monitors
	// ------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (cmd_valid === 1'b1)
			check("cmd", {8'h00, d_read, d_code}, pop(q_cmd));
		if (wr_valid === 1'b1)
			check("wr_data", {8'h00, d_wdat}, pop(q_wr));
		if (h_done === 1'b1)
		begin
			e_host = pop(q_host);
			check("err", {15'h0000, h_err}, {15'h0000, e_host[8]});
			check("busy_end", {15'h0000, h_busy}, 16'h0000);
			if (e_host[9])
				check("rd_data", {8'h00, h_rdat}, {8'h00, e_host[7:0]});
		end
		// Decode the wire by low width; a break restarts the bit count
		if ((swrt_if_inst.alert_line & swrt_if_inst.ded_line) !== 1'b1)
			lo_n++;
		else if (lo_n != 0)
		begin
			if (lo_n >= swrt_pkg::BRK_DET_CYC)
				nbit = 0;
			else
			begin
				wb = {lo_n < swrt_pkg::THRESH_CYC, wb[15:1]};
				nbit++;
			end
			if (nbit == 16)
			begin
				check("wire", wb, pop(q_wire));
				nbit = 0;
			end
			lo_n = 0;
		end
		cyc++;
		if (cyc == 170000)
		begin
			n_fail++;
			test_done;
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		seed = $urandom(97);
		repeat (20) @(posedge clk_sys);
		nrst <= 1;
		repeat (3) @(posedge clk_sys);
		check("sw_mode", sw_mode, 1);
		check("alert_sel", alert_sel, 0);
		comm_cfg <= 0;
		mode(1, 1, 1, 1);
		xact(0, 7'($urandom), 8'($urandom));
		comm_cfg <= 1;
		mode(1, 0, 1, 0);
		use_alert <= 0;
		xact(1, 7'($urandom), 8'($urandom));
		comm_cfg <= 0;
		mode(1, 0, 0, 0);
		test_done;
	end
endmodule
